//--- core/hpm_pkg.sv
// constants and types of the host port mode pin mux
// assumes a single 20 MHz clock domain and a 32-bit AXI4-Lite register bus
package hpm_pkg;
   typedef enum logic [1:0] {
      HPM_MUX    = 2'h0,
      HPM_NONMUX = 2'h1,
      HPM_SERIAL = 2'h2,
      HPM_HW     = 2'h3
   } hpm_mode_t;

   // ==========================================================
   // register map
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_STATE    = 8'h04;
   localparam logic [7:0]  OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0]  OFF_IRQ_MASK = 8'h0c;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ==========================================================
   // control and interrupt fields
   localparam int          CTRL_W        = 2;
   localparam int          CTRL_INT_EN   = 0;
   localparam int          CTRL_FREEZE   = 1;
   localparam logic [1:0]  CTRL_RST      = 2'h1;
   localparam int          IRQ_W         = 8;
   localparam int          IRQ_MODE_BIT  = 0;
   localparam int          IRQ_FLOAT_BIT = 1;
   localparam int          IRQ_EXT_LSB   = 2;
   localparam int          EXT_W         = 6;
   localparam logic [7:0]  MASK_RST      = 8'h00;

   // ==========================================================
   // shared bus bit positions
   localparam int          MISO_BIT  = 0;
   localparam int          MOSI_BIT  = 1;
   localparam int          SCLK_BIT  = 2;
   localparam int          RX_SYNC_BIT = 2;
   localparam int          TX_SYNC_BIT = 3;
   localparam int          RFRM0_BIT   = 4;
   localparam int          RFRM1_BIT   = 5;
   localparam int          TX_TERM_BIT = 6;
   localparam int          RX_TERM_BIT = 7;
endpackage

//--- core/hpm_strap_if.sv
// strap capture signals between the pin mux top and its strap latch
// assumes both ends share the top's clock
`timescale 1ns/100ps
`default_nettype none
interface hpm_strap_if;
   logic       hw_mode;
   logic       freeze;
   logic [7:2] bus;
   logic [1:0] tmode;
   logic       jacks;
   logic       rx_term_dis;
   logic       tx_term_dis;
   logic [1:0] rx_fram;
   logic [1:0] tx_mode;
   logic       tx_sync;
   logic       rx_sync;
   logic       jacks_sel;

   modport strap (input hw_mode, freeze, bus, tmode, jacks,
                  output rx_term_dis, tx_term_dis, rx_fram, tx_mode, tx_sync, rx_sync, jacks_sel);
   modport core  (output hw_mode, freeze, bus, tmode, jacks,
                  input rx_term_dis, tx_term_dis, rx_fram, tx_mode, tx_sync, rx_sync, jacks_sel);
endinterface
`default_nettype wire

//--- core/hpm_strap.sv
// latch of the static strap levels used in hardware mode
// assumes strap pins are synchronous and steady while in hardware mode
`timescale 1ns/100ps
`default_nettype none
module hpm_strap (
   input wire logic     clk,
   input wire logic     sys_rst,
   hpm_strap_if.strap   sif
);
   // ==========================================================
   // capture
   // straps follow the pins only in hardware mode; freeze keeps a known set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sif.rx_term_dis <= 1'b0;
         sif.tx_term_dis <= 1'b0;
         sif.rx_fram     <= 2'h0;
         sif.tx_mode     <= 2'h0;
         sif.tx_sync     <= 1'b0;
         sif.rx_sync     <= 1'b0;
         sif.jacks_sel   <= 1'b0;
      end else if (sif.hw_mode && !sif.freeze) begin
         sif.rx_term_dis <= sif.bus[hpm_pkg::RX_TERM_BIT];                                // RL9
         sif.tx_term_dis <= sif.bus[hpm_pkg::TX_TERM_BIT];                                // RL9
         sif.rx_fram     <= {sif.bus[hpm_pkg::RFRM1_BIT], sif.bus[hpm_pkg::RFRM0_BIT]};   // RL10
         sif.tx_mode     <= sif.tmode;                                                    // RL4
         sif.tx_sync     <= sif.bus[hpm_pkg::TX_SYNC_BIT];                                // RL11
         sif.rx_sync     <= sif.bus[hpm_pkg::RX_SYNC_BIT];                                // RL12
         sif.jacks_sel   <= sif.jacks;                                                    // RL15
      end
   end

   // ==========================================================
   // checks
   property p_rx_term;
      @(posedge clk) disable iff (sys_rst)
      (sif.hw_mode && !sif.freeze) |=> (sif.rx_term_dis == $past(sif.bus[hpm_pkg::RX_TERM_BIT])
                                        && sif.tx_term_dis == $past(sif.bus[hpm_pkg::TX_TERM_BIT]));
   endproperty
   a_rx_term: assert property (p_rx_term) else $error("termination strap not taken"); // RL9
   property p_rx_fram;
      @(posedge clk) disable iff (sys_rst)
      (sif.hw_mode && !sif.freeze) |=> (sif.rx_fram == $past(sif.bus[5:4]));
   endproperty
   a_rx_fram: assert property (p_rx_fram) else $error("rx framing strap not taken"); // RL10
   property p_sync_sel;
      @(posedge clk) disable iff (sys_rst)
      (sif.hw_mode && !sif.freeze) |=> (sif.tx_sync == $past(sif.bus[3]) && sif.rx_sync == $past(sif.bus[2]));
   endproperty
   a_sync_sel: assert property (p_sync_sel) else $error("sync function strap not taken"); // RL11
   property p_hold;
      @(posedge clk) disable iff (sys_rst)
      (!sif.hw_mode || sif.freeze) |=> $stable(sif.rx_sync) && $stable(sif.tx_mode) && $stable(sif.rx_fram);
   endproperty
   a_hold: assert property (p_hold) else $error("straps moved outside hardware mode"); // RL12
endmodule
`default_nettype wire

//--- core/hpm_top.sv
// host port mode pin mux: decodes the host port select pair and routes the
// shared bus pins, drives the open-drain interrupt, handles reset/float pin
// assumes all pin inputs synchronous to clk; AXI4-Lite slave on register side
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RL1] select pair picks one of four host modes
// [RL2] interrupt pin pulled low on pending events
// [RL3] board drives jitter clock select in hardware mode
// [RL4] transmit mode selects form mode code in hardware
// [RL5] reset pin rising edge restores register defaults
// [RL6] reset pin high floats every driven pin
// [RL7] nonmultiplexed mode: bus is plain data
// [RL8] multiplexed mode: bus is address/data
// [RL9] hardware mode: bits seven, six disable terminations
// [RL10] hardware mode: bits five, four pick framing
// [RL11] hardware mode: bit three picks tx sync function
// [RL12] hardware mode: bit two picks rx sync function
// [RL13] serial mode: bit two is serial clock
// [RL14] serial mode: bit zero out, bit one in
// [RL15] hardware mode: straps static, no bus drive
// [RL16] ignore serial clock and bus cycles elsewhere
module hpm_top (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq,
   input  wire logic [1:0]  host_port_select,
   input  wire logic        reset_float_pin,
   input  wire logic        tx_mode_sel1,
   input  wire logic        tx_mode_sel2,
   input  wire logic        int_jacks_i,
   output logic             int_jacks_o,
   output logic             int_jacks_oe,
   input  wire logic [7:0]  ad_i,
   output logic [7:0]       ad_o,
   output logic [7:0]       ad_oe,
   input  wire logic [5:0]  dev_event,
   input  wire logic [7:0]  par_rdata,
   input  wire logic        par_drive,
   input  wire logic        miso_data,
   input  wire logic        miso_drive,
   output logic [1:0]       host_mode,
   output logic             par_mux_en,
   output logic             par_nonmux_en,
   output logic             serial_en,
   output logic [7:0]       par_din,
   output logic             sclk,
   output logic             mosi,
   output logic             cfg_reset,
   output logic             rx_term_disable,
   output logic             tx_term_disable,
   output logic [1:0]       rx_framing_sel,
   output logic             tx_sync_pin_function,
   output logic             rx_sync_pin_function,
   output logic [1:0]       tx_mode_code,
   output logic             jitter_att_clk_sel0
);
   // ==========================================================
   // helpers
   function automatic logic is_par(input logic [1:0] m);
      is_par = (m == hpm_pkg::HPM_MUX) || (m == hpm_pkg::HPM_NONMUX);
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == hpm_pkg::OFF_CTRL) || (a == hpm_pkg::OFF_STATE) ||
                (a == hpm_pkg::OFF_IRQ_STAT) || (a == hpm_pkg::OFF_IRQ_MASK);
   endfunction

   hpm_pkg::hpm_mode_t mode;
   logic                       float_d_r;
   logic                       float_rise;
   logic [1:0]                 mode_prev_r;
   logic [hpm_pkg::CTRL_W-1:0] ctrl_r;
   logic [hpm_pkg::IRQ_W-1:0]  stat_r;
   logic [hpm_pkg::IRQ_W-1:0]  mask_r;
   logic [hpm_pkg::IRQ_W-1:0]  stat_set;
   logic [hpm_pkg::IRQ_W-1:0]  stat_clr;
   logic                       pend;
   logic                       aw_got_r;
   logic                       w_got_r;
   logic [7:0]                 aw_addr_r;
   logic [31:0]                w_data_r;
   logic [3:0]                 w_strb_r;
   logic                       wr_fire;
   logic                       rd_fire;
   logic [31:0]                state_word;

   hpm_strap_if sif ();

   // ==========================================================
   // mode decode
   assign mode       = hpm_pkg::hpm_mode_t'(host_port_select);   // RL1
   assign float_rise = reset_float_pin && !float_d_r;             // RL5

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_mode     <= 2'h0;
         par_mux_en    <= 1'b0;
         par_nonmux_en <= 1'b0;
         serial_en     <= 1'b0;
      end else begin
         host_mode     <= mode;                                   // RL1
         par_mux_en    <= (mode == hpm_pkg::HPM_MUX);            // RL1
         par_nonmux_en <= (mode == hpm_pkg::HPM_NONMUX);         // RL1
         serial_en     <= (mode == hpm_pkg::HPM_SERIAL);         // RL1
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         float_d_r   <= 1'b0;
         mode_prev_r <= 2'h0;
         cfg_reset   <= 1'b0;
      end else begin
         float_d_r   <= reset_float_pin;
         mode_prev_r <= host_port_select;
         cfg_reset   <= float_rise;                               // RL5
      end
   end

   // ==========================================================
   // shared pin routing
   // float wins over every mode so board test sees no driver
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ad_o    <= 8'h00;
         ad_oe   <= 8'h00;
         par_din <= 8'h00;
         sclk    <= 1'b0;
         mosi    <= 1'b0;
      end else begin
         ad_o  <= 8'h00;
         ad_oe <= 8'h00;                                          // RL6 RL15
         sclk  <= 1'b0;                                           // RL16
         mosi  <= 1'b0;
         if (!reset_float_pin) begin
            unique case (mode)
               hpm_pkg::HPM_MUX, hpm_pkg::HPM_NONMUX: begin
                  ad_o    <= par_rdata;                           // RL7 RL8
                  ad_oe   <= {8{par_drive}};                      // RL7 RL8
                  par_din <= ad_i;                                // RL7 RL8
               end
               hpm_pkg::HPM_SERIAL: begin
                  ad_o[hpm_pkg::MISO_BIT]  <= miso_data;          // RL14
                  ad_oe[hpm_pkg::MISO_BIT] <= miso_drive;         // RL14
                  mosi                     <= ad_i[hpm_pkg::MOSI_BIT];   // RL14
                  sclk                     <= ad_i[hpm_pkg::SCLK_BIT];   // RL13
               end
               hpm_pkg::HPM_HW: begin
               end
            endcase
         end
      end
   end

   // open-drain: output level is always low, only the enable moves
   // in hardware mode the pin is the jitter clock select strap instead
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_jacks_o  <= 1'b0;
         int_jacks_oe <= 1'b0;
         irq          <= 1'b0;
      end else begin
         int_jacks_o  <= 1'b0;
         int_jacks_oe <= pend && !reset_float_pin && (mode != hpm_pkg::HPM_HW);   // RL2 RL6
         irq          <= |(stat_r & mask_r);
      end
   end

   // ==========================================================
   // hardware mode straps
   assign sif.hw_mode = (mode == hpm_pkg::HPM_HW);                // RL15
   assign sif.freeze  = ctrl_r[hpm_pkg::CTRL_FREEZE];
   assign sif.bus     = ad_i[7:2];
   assign sif.tmode   = {tx_mode_sel2, tx_mode_sel1};              // RL4
   assign sif.jacks   = int_jacks_i;                               // RL3

   hpm_strap u_strap (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sif     (sif)
   );

   assign rx_term_disable      = sif.rx_term_dis;
   assign tx_term_disable      = sif.tx_term_dis;
   assign rx_framing_sel       = sif.rx_fram;
   assign tx_sync_pin_function = sif.tx_sync;
   assign rx_sync_pin_function = sif.rx_sync;
   assign tx_mode_code         = sif.tx_mode;
   assign jitter_att_clk_sel0  = sif.jacks_sel;

   // ==========================================================
   // interrupt status
   assign pend     = |(stat_r & mask_r) && ctrl_r[hpm_pkg::CTRL_INT_EN];
   assign stat_set = {dev_event, float_rise, (mode_prev_r != host_port_select)};
   assign rd_fire  = s_axi_arvalid && s_axi_arready;
   assign stat_clr = (rd_fire && s_axi_araddr == hpm_pkg::OFF_IRQ_STAT) ? stat_r : '0;

   // set wins over the read clear so an event in the clearing cycle survives
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_r <= '0;
      end else if (float_rise) begin
         stat_r <= stat_set;                                      // RL5
      end else begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;               // RL2
      end
   end

   // ==========================================================
   // AXI4-Lite write side
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h00000000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= hpm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r      <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r      <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_addr_r) ? hpm_pkg::RESP_OKAY : hpm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= hpm_pkg::CTRL_RST;
         mask_r <= hpm_pkg::MASK_RST;
      end else if (float_rise) begin
         ctrl_r <= hpm_pkg::CTRL_RST;                             // RL5
         mask_r <= hpm_pkg::MASK_RST;                             // RL5
      end else if (wr_fire && w_strb_r[0]) begin
         if (aw_addr_r == hpm_pkg::OFF_CTRL)
            ctrl_r <= w_data_r[hpm_pkg::CTRL_W-1:0];
         if (aw_addr_r == hpm_pkg::OFF_IRQ_MASK)
            mask_r <= w_data_r[hpm_pkg::IRQ_W-1:0];
      end
   end

   // ==========================================================
   // AXI4-Lite read side
   assign state_word = {20'h00000, sif.rx_term_dis, sif.tx_term_dis, sif.rx_fram, sif.tx_sync, sif.rx_sync,
                        sif.tx_mode, sif.jacks_sel, reset_float_pin, host_port_select};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= hpm_pkg::RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= reg_hit(s_axi_araddr) ? hpm_pkg::RESP_OKAY : hpm_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
               hpm_pkg::OFF_CTRL:     s_axi_rdata <= {30'h00000000, ctrl_r};
               hpm_pkg::OFF_STATE:    s_axi_rdata <= state_word;
               hpm_pkg::OFF_IRQ_STAT: s_axi_rdata <= {24'h000000, stat_r};
               hpm_pkg::OFF_IRQ_MASK: s_axi_rdata <= {24'h000000, mask_r};
               default:               s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   property p_mode_dec;
      @(posedge clk) disable iff (sys_rst)
      1'b1 |=> (serial_en == ($past(host_port_select) == 2'h2)) && (par_mux_en == ($past(host_port_select) == 2'h0));
   endproperty
   a_mode_dec: assert property (p_mode_dec) else $error("host mode decode wrong"); // RL1
   property p_int_pin;
      @(posedge clk) disable iff (sys_rst)
      (pend && !reset_float_pin && host_port_select != 2'h3) |=> int_jacks_oe && !int_jacks_o;
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("interrupt pin not pulled low"); // RL2
   property p_cfg_rst;
      @(posedge clk) disable iff (sys_rst)
      (reset_float_pin && !float_d_r) |=> cfg_reset && ctrl_r == hpm_pkg::CTRL_RST && mask_r == 8'h00 ##1 !cfg_reset;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst) else $error("reset pin edge did not restore defaults"); // RL5
   property p_float;
      @(posedge clk) disable iff (sys_rst)
      reset_float_pin |=> ad_oe == 8'h00 && !int_jacks_oe;
   endproperty
   a_float: assert property (p_float) else $error("pin driven while floated"); // RL6
   property p_par_bus;
      @(posedge clk) disable iff (sys_rst)
      (!reset_float_pin && host_port_select[1] == 1'b0) |=> par_din == $past(ad_i) && ad_oe == {8{$past(par_drive)}};
   endproperty
   a_par_bus: assert property (p_par_bus) else $error("parallel bus not routed"); // RL7
   property p_mux_out;
      @(posedge clk) disable iff (sys_rst)
      (!reset_float_pin && host_port_select == 2'h0 && par_drive) |=> ad_o == $past(par_rdata);
   endproperty
   a_mux_out: assert property (p_mux_out) else $error("multiplexed bus data wrong"); // RL8
   property p_sclk;
      @(posedge clk) disable iff (sys_rst)
      (!reset_float_pin && host_port_select == 2'h2) |=> sclk == $past(ad_i[2]) && mosi == $past(ad_i[1]);
   endproperty
   a_sclk: assert property (p_sclk) else $error("serial clock or data in not routed"); // RL13
   property p_miso;
      @(posedge clk) disable iff (sys_rst)
      (!reset_float_pin && host_port_select == 2'h2) |=> ad_oe == {7'h00, $past(miso_drive)};
   endproperty
   a_miso: assert property (p_miso) else $error("serial data out drive wrong"); // RL14
   property p_hw_quiet;
      @(posedge clk) disable iff (sys_rst)
      (host_port_select == 2'h3) |=> ad_oe == 8'h00 && !int_jacks_oe;
   endproperty
   a_hw_quiet: assert property (p_hw_quiet) else $error("bus driven in hardware mode"); // RL15
   property p_no_sclk;
      @(posedge clk) disable iff (sys_rst)
      (host_port_select != 2'h2) |=> !sclk;
   endproperty
   a_no_sclk: assert property (p_no_sclk) else $error("serial clock passed outside serial mode"); // RL16
   property p_tx_mode;
      @(posedge clk) disable iff (sys_rst)
      (host_port_select == 2'h3 && !ctrl_r[1]) |=> tx_mode_code == {$past(tx_mode_sel2), $past(tx_mode_sel1)};
   endproperty
   a_tx_mode: assert property (p_tx_mode) else $error("tx mode code not taken"); // RL4

   c_serial: cover property (@(posedge clk) disable iff (sys_rst) serial_en && sclk);
   c_hw:     cover property (@(posedge clk) disable iff (sys_rst) host_port_select == 2'h3 ##1 jitter_att_clk_sel0);
   c_int:    cover property (@(posedge clk) disable iff (sys_rst) !int_jacks_oe ##1 int_jacks_oe);
   c_float:  cover property (@(posedge clk) disable iff (sys_rst) cfg_reset);
endmodule
`default_nettype wire

//--- tb/hpm_host_model.sv
// host and board side of the shared pins
// assumes the bench sets the pattern and strap the host offers
`timescale 1ns/100ps
`default_nettype none
module hpm_host_model (
   input  wire logic [7:0] pat,
   input  wire logic       jk,
   input  wire logic       hw,
   input  wire logic [7:0] ad_o,
   input  wire logic [7:0] ad_oe,
   input  wire logic       int_oe,
   output logic [7:0]      ad_i,
   output logic            int_i
);
   // host drives every bit the device leaves free, clock included
   assign ad_i = (ad_oe & ad_o) | (~ad_oe & pat);
   // pull-up on the open-drain pin; strap driven only in hardware mode
   assign int_i = int_oe ? 1'h0 : (hw ? jk : 1'h1);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// bench for the host port mode pin mux
// assumes hpm_pkg, hpm_strap_if, hpm_strap, hpm_top and the host model
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk='0, sys_rst='1, s_axi_awvalid='0, s_axi_wvalid='0, s_axi_bready='0, s_axi_arvalid='0;
   logic s_axi_rready='0, reset_float_pin='0, tx_mode_sel1='0, tx_mode_sel2='0, par_drive='0, jk='0;
   logic miso_data='0, miso_drive='0, irq, int_jacks_i, int_jacks_o, int_jacks_oe, sclk, mosi, cfg_reset;
   logic [7:0] s_axi_awaddr='0, s_axi_araddr='0, par_rdata='0, pat='0, ad_i, ad_o, ad_oe, par_din;
   logic [31:0] s_axi_wdata='0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb=4'hf;
   logic [5:0] dev_event='0;
   logic [1:0] host_port_select='0, s_axi_bresp, s_axi_rresp, host_mode, rx_framing_sel, tx_mode_code, rsp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, par_mux_en, par_nonmux_en;
   logic serial_en, rx_term_disable, tx_term_disable, tx_sync_pin_function, rx_sync_pin_function;
   logic jitter_att_clk_sel0;
   int failures=0, n_tests=0;
   hpm_top u_hpm_top (.*);
   hpm_host_model u_hpm_host_model (.pat(pat), .jk(jk), .hw(host_port_select == 2'h3), .ad_o(ad_o),
      .ad_oe(ad_oe), .int_oe(int_jacks_oe), .ad_i(ad_i), .int_i(int_jacks_i));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // register bus cycles, entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 40 && !s_axi_bvalid; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      rsp = s_axi_bresp;
      if (i == 40) begin
         failures++;
         wrap_up();
      end
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 40 && !s_axi_rvalid; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      if (i == 40) begin
         failures++;
         wrap_up();
      end
      @(posedge clk);
   endtask
   initial begin
      int k;
      logic [1:0] m;
      logic [7:0] p, q, oe, w;
      void'($urandom(32'h2d3e));
      repeat (20) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      // each mode with device drive off and on
      for (k = 0; k < 8; k++) begin
         m = 2'(k >> 1);
         p = 8'($urandom);
         q = 8'($urandom);
         host_port_select <= m;
         pat <= p;
         par_rdata <= q;
         par_drive <= k[0];
         miso_drive <= k[0];
         miso_data <= q[0];
         tx_mode_sel1 <= p[0];
         tx_mode_sel2 <= p[1];
         jk <= p[7];
         repeat (3) @(posedge clk);
         oe = m < 2 ? {8{k[0]}} : {7'h0, m == 2 && k[0]};
         w = (oe & (m < 2 ? q : {7'h0, q[0]})) | (~oe & p);
         chk("mode", {m, m == 0, m == 1, m == 2}, {host_mode, par_mux_en, par_nonmux_en, serial_en});
         chk("ad_oe", oe, ad_oe);
         chk("ad_o", oe & w, oe & ad_o);
         chk("serial", m == 2 ? w[2:1] : 2'h0, {sclk, mosi});
         if (m < 2) chk("par_din", w, par_din);
         if (m == 3) chk("straps", {p, p[7]}, {rx_term_disable, tx_term_disable, rx_framing_sel,
            tx_sync_pin_function, rx_sync_pin_function, tx_mode_code, jitter_att_clk_sel0});
      end
      $display("mode sweep done");
      host_port_select <= 2'h0;
      par_drive <= 1'h0;
      miso_drive <= 1'h0;
      repeat (3) @(posedge clk);
      rd_reg(hpm_pkg::OFF_IRQ_STAT);
      wr(hpm_pkg::OFF_IRQ_MASK, 32'h4);
      chk("bresp", hpm_pkg::RESP_OKAY, rsp);
      // first event unmasked, second masked
      for (k = 0; k < 2; k++) begin
         dev_event <= 6'(1 << k);
         @(posedge clk);
         dev_event <= 6'h0;
         repeat (3) @(posedge clk);
         chk("irq", {k == 0, k == 0}, {irq, int_jacks_oe});
         rd_reg(hpm_pkg::OFF_IRQ_STAT);
         chk("stat", 32'h4 << k, rd);
         repeat (2) @(posedge clk);
         chk("irq_clr", 2'h0, {irq, int_jacks_oe});
      end
      rd_reg(8'h40);
      chk("rresp", hpm_pkg::RESP_SLVERR, rsp);
      chk("unmapped", 32'h0, rd);
      wr(8'h44, 32'h0);
      chk("bresp_bad", hpm_pkg::RESP_SLVERR, rsp);
      $display("irq test done");
      host_port_select <= 2'h1;
      par_drive <= 1'h1;
      wr(hpm_pkg::OFF_CTRL, 32'h2);
      reset_float_pin <= 1'h1;
      repeat (2) @(posedge clk);
      chk("cfg_reset", 1'h1, cfg_reset);
      @(posedge clk);
      chk("float", 10'h0, {cfg_reset, int_jacks_oe, ad_oe});
      rd_reg(hpm_pkg::OFF_CTRL);
      chk("ctrl", {30'h0, hpm_pkg::CTRL_RST}, rd);
      rd_reg(hpm_pkg::OFF_IRQ_MASK);
      chk("mask", {24'h0, hpm_pkg::MASK_RST}, rd);
      reset_float_pin <= 1'h0;
      $display("float test done");
      wrap_up();
   end
endmodule
`default_nettype wire
